// File: ecp_pkg.sv
// constants, field layouts and carrier types of the configuration preloader
package ecp_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_PORTS = 4;
  localparam int NUM_STEPS = 7;
  localparam int STEP_W = 3;
  localparam int ROM_AW = 8;
  localparam int WORD_W = 16;

  // ----------------------------------------------------------------
  // eeprom word addresses, index of each word in the load sequence
  // ----------------------------------------------------------------
  localparam logic [STEP_W-1:0] STEP_SIG = 3'h0;
  localparam logic [STEP_W-1:0] STEP_VID = 3'h1;
  localparam logic [STEP_W-1:0] STEP_DID = 3'h2;
  localparam logic [STEP_W-1:0] STEP_W06 = 3'h3;
  localparam logic [STEP_W-1:0] STEP_SVID = 3'h4;
  localparam logic [STEP_W-1:0] STEP_SID = 3'h5;
  localparam logic [STEP_W-1:0] STEP_W0C = 3'h6;
  localparam logic [STEP_W-1:0] STEP_LAST = 3'h6;

  // ----------------------------------------------------------------
  // reset values of the loaded words
  // ----------------------------------------------------------------
  localparam logic [WORD_W-1:0] DEF_W06 = 16'h0806;
  localparam logic [WORD_W-1:0] DEF_W0C = 16'h001d;
  localparam logic [WORD_W-1:0] DEF_SUBVID = 16'h0000;
  localparam logic [WORD_W-1:0] DEF_SUBID = 16'h0000;

  // ----------------------------------------------------------------
  // field positions inside word 06h
  // ----------------------------------------------------------------
  localparam int W06_EXTVC = 0;
  localparam int W06_L0S = 1;
  localparam int W06_L1 = 4;
  localparam int W06_NOEGR = 8;
  localparam int W06_NOTAG = 9;
  localparam int W06_SAF = 10;
  localparam int W06_CUT = 11;
  localparam int W06_ARB = 13;
  localparam int W06_CRED = 14;
  localparam int W06_INTA = 15;

  // ----------------------------------------------------------------
  // field positions inside word 0Ch
  // ----------------------------------------------------------------
  localparam int W0C_MPS = 0;
  localparam int W0C_ASPM = 2;
  localparam int W0C_RBER = 4;
  localparam int W0C_MSIDIS = 5;
  localparam int W0C_CPDIS = 6;
  localparam int W0C_PMDIS = 7;
  localparam int W0C_PPNP = 8;
  localparam int W0C_LBN = 9;

  // ----------------------------------------------------------------
  // apb register map (byte addresses) and bits
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IDS = 8'h08;
  localparam logic [7:0] REG_SUBIDS = 8'h0c;
  localparam logic [7:0] REG_W06 = 8'h10;
  localparam logic [7:0] REG_W0C = 8'h14;
  localparam int CTRL_RELOAD = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_MATCH = 2;
  localparam int STAT_BAD = 3;

  // ----------------------------------------------------------------
  // per-port configuration fields driven into the switch core
  // ----------------------------------------------------------------
  typedef struct packed {
    logic extVcCount;
    logic [2:0] l0sExitLat;
    logic [2:0] l1ExitLat;
    logic [1:0] aspmSupport;
    logic linkBwNotif;
    logic noEgressOrder;
    logic noTagOrder;
    logic storeForward;
    logic [1:0] cutThruThresh;
    logic arbMode;
    logic creditMode;
    logic complParityDis;
    logic msiCapDis;
    logic pmCapDis;
    logic intaPin;
    logic [1:0] maxPayload;
    logic roleErrReport;
    logic postPassNp;
  } ecpCfgPort_type;

  typedef struct packed {
    logic [WORD_W-1:0] vendorId;
    logic [WORD_W-1:0] deviceId;
    logic [WORD_W-1:0] subVendorId;
    logic [WORD_W-1:0] subsystemId;
  } ecpIds_type;

endpackage

// File: ecp_preload.sv
// eeprom configuration preloader: word sequencer, field mapping, apb registers
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module ecp_preload #(
  // arbitrary neutral values
  parameter logic [15:0] SIGNATURE = 16'ha55a,
  parameter logic [15:0] DEF_VENDOR = 16'h1234,
  parameter logic [15:0] DEF_DEVICE = 16'h5678
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic wordReq,
  output logic [ecp_pkg::ROM_AW-1:0] wordAddr,
  input wire logic [ecp_pkg::WORD_W-1:0] wordData,
  input wire logic wordAck,
  output ecp_pkg::ecpIds_type ids,
  output ecp_pkg::ecpCfgPort_type [ecp_pkg::NUM_PORTS-1:0] cfgPort,
  output logic loadBusy,
  output logic loadDone,
  output logic sigMismatch
);

  typedef enum logic [1:0] {ST_ISSUE, ST_WAIT, ST_IDLE} ecpState_type;

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  function automatic logic [ecp_pkg::ROM_AW-1:0] stepAddr(
    input logic [ecp_pkg::STEP_W-1:0] s
  );
    // word n of the sequence sits at byte address 2n
    stepAddr = {4'h0, s, 1'b0};
  endfunction

  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == ecp_pkg::REG_CTRL) || (a == ecp_pkg::REG_STATUS) ||
               (a == ecp_pkg::REG_IDS) || (a == ecp_pkg::REG_SUBIDS) ||
               (a == ecp_pkg::REG_W06) || (a == ecp_pkg::REG_W0C);
  endfunction

  function automatic ecp_pkg::ecpCfgPort_type mapPort(
    input int p,
    input logic [15:0] w06,
    input logic [15:0] w0c
  );
    ecp_pkg::ecpCfgPort_type c;
    c = '0;
    c.extVcCount = w06[ecp_pkg::W06_EXTVC];
    c.l0sExitLat = w06[ecp_pkg::W06_L0S +: 3];
    c.l1ExitLat = w06[ecp_pkg::W06_L1 +: 3];
    c.noEgressOrder = w06[ecp_pkg::W06_NOEGR];
    c.noTagOrder = w06[ecp_pkg::W06_NOTAG];
    c.storeForward = w06[ecp_pkg::W06_SAF];
    c.cutThruThresh = w06[ecp_pkg::W06_CUT +: 2];
    c.arbMode = w06[ecp_pkg::W06_ARB];
    c.creditMode = w06[ecp_pkg::W06_CRED];
    // the upstream port has no interrupt pin and no bandwidth notification
    c.intaPin = (p != 0) && w06[ecp_pkg::W06_INTA];
    c.maxPayload = w0c[ecp_pkg::W0C_MPS +: 2];
    c.aspmSupport = w0c[ecp_pkg::W0C_ASPM +: 2];
    c.roleErrReport = w0c[ecp_pkg::W0C_RBER];
    c.msiCapDis = w0c[ecp_pkg::W0C_MSIDIS];
    c.complParityDis = w0c[ecp_pkg::W0C_CPDIS];
    c.pmCapDis = w0c[ecp_pkg::W0C_PMDIS];
    c.postPassNp = w0c[ecp_pkg::W0C_PPNP];
    c.linkBwNotif = (p != 0) && w0c[ecp_pkg::W0C_LBN];
    mapPort = c;
  endfunction

  // ----------------------------------------------------------------
  // word fetch
  // ----------------------------------------------------------------
  logic fetchStart;
  logic fetchDone;
  logic [ecp_pkg::WORD_W-1:0] fetchData;
  ecpState_type state;
  ecpState_type next_state;
  logic [ecp_pkg::STEP_W-1:0] step;
  logic [ecp_pkg::STEP_W-1:0] next_step;

  // the fetch holds wordReq and wordAddr on its own until the acknowledge edge
  assign fetchStart = (state == ST_ISSUE);

  ecp_word_fetch u_fetch (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(fetchStart),
    .addr(stepAddr(step)),
    .done(fetchDone),
    .data(fetchData),
    .wordReq(wordReq),
    .wordAddr(wordAddr),
    .wordData(wordData),
    .wordAck(wordAck)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  logic [ecp_pkg::WORD_W-1:0] wordBuf [ecp_pkg::NUM_STEPS];
  logic [ecp_pkg::WORD_W-1:0] next_wordBuf [ecp_pkg::NUM_STEPS];
  logic reloadReq;
  logic commitLoad;
  logic commitDefault;

  // a word costs an issue cycle, the wait for its acknowledge and one cycle
  // to see the registered done, so the next request rises three cycles after the acknowledge
  always_comb begin
    next_state = state;
    next_step = step;
    next_wordBuf = wordBuf;
    commitLoad = 1'b0;
    commitDefault = 1'b0;
    unique case (state)
      ST_ISSUE: begin
        next_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (fetchDone) begin
          next_wordBuf[step] = fetchData;
          if (step == ecp_pkg::STEP_SIG && fetchData != SIGNATURE) begin
            // no valid image: stop early and fall back to defaults
            commitDefault = 1'b1;
            next_state = ST_IDLE;
          end else if (step == ecp_pkg::STEP_LAST) begin
            // everything is applied at once, never a half-loaded image
            commitLoad = 1'b1;
            next_state = ST_IDLE;
          end else begin
            next_step = step + 3'h1;
            next_state = ST_ISSUE;
          end
        end
      end
      ST_IDLE: begin
        // a reload while a load runs is ignored
        if (reloadReq) begin
          next_step = ecp_pkg::STEP_SIG;
          next_state = ST_ISSUE;
        end
      end
      default: begin
        // an illegal code parks the sequencer; a reload restarts it
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_ISSUE;
      step <= 3'h0;
      for (int i = 0; i < ecp_pkg::NUM_STEPS; i++) begin
        wordBuf[i] <= 16'h0000;
      end
    end else begin
      state <= next_state;
      step <= next_step;
      wordBuf <= next_wordBuf;
    end
  end

  // ----------------------------------------------------------------
  // live words and status
  // ----------------------------------------------------------------
  logic [15:0] w06Live;
  logic [15:0] w0cLive;
  logic [15:0] next_w06Live;
  logic [15:0] next_w0cLive;
  ecp_pkg::ecpIds_type next_ids;
  logic next_loadBusy;
  logic next_loadDone;
  logic next_sigMismatch;

  // a mismatch also wipes an earlier good image, never a stale mix
  always_comb begin
    next_w06Live = w06Live;
    next_w0cLive = w0cLive;
    next_ids = ids;
    next_loadDone = loadDone;
    next_sigMismatch = sigMismatch;
    next_loadBusy = (next_state != ST_IDLE);
    if (state == ST_IDLE && reloadReq) begin
      next_loadDone = 1'b0;
      next_sigMismatch = 1'b0;
    end
    if (commitLoad) begin
      next_w06Live = wordBuf[ecp_pkg::STEP_W06];
      next_w0cLive = fetchData;
      next_ids.vendorId = wordBuf[ecp_pkg::STEP_VID];
      next_ids.deviceId = wordBuf[ecp_pkg::STEP_DID];
      next_ids.subVendorId = wordBuf[ecp_pkg::STEP_SVID];
      next_ids.subsystemId = wordBuf[ecp_pkg::STEP_SID];
      next_loadDone = 1'b1;
    end else if (commitDefault) begin
      next_w06Live = ecp_pkg::DEF_W06;
      next_w0cLive = ecp_pkg::DEF_W0C;
      next_ids.vendorId = DEF_VENDOR;
      next_ids.deviceId = DEF_DEVICE;
      next_ids.subVendorId = ecp_pkg::DEF_SUBVID;
      next_ids.subsystemId = ecp_pkg::DEF_SUBID;
      next_loadDone = 1'b1;
      next_sigMismatch = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      w06Live <= ecp_pkg::DEF_W06;
      w0cLive <= ecp_pkg::DEF_W0C;
      ids.vendorId <= DEF_VENDOR;
      ids.deviceId <= DEF_DEVICE;
      ids.subVendorId <= ecp_pkg::DEF_SUBVID;
      ids.subsystemId <= ecp_pkg::DEF_SUBID;
      loadBusy <= 1'b1;
      loadDone <= 1'b0;
      sigMismatch <= 1'b0;
    end else begin
      w06Live <= next_w06Live;
      w0cLive <= next_w0cLive;
      ids <= next_ids;
      loadBusy <= next_loadBusy;
      loadDone <= next_loadDone;
      sigMismatch <= next_sigMismatch;
    end
  end

  // ----------------------------------------------------------------
  // per-port field registers
  // ----------------------------------------------------------------
  // fields follow the live words, so they change in the same cycle as loadDone
  for (genvar p = 0; p < ecp_pkg::NUM_PORTS; p++) begin : g_port
    // reset image of the port: the mapping of the default words, a constant
    localparam ecp_pkg::ecpCfgPort_type RST_CFG =
      mapPort(p, ecp_pkg::DEF_W06, ecp_pkg::DEF_W0C);
    ecp_pkg::ecpCfgPort_type next_cfg;

    always_comb begin
      next_cfg = mapPort(p, next_w06Live, next_w0cLive);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        cfgPort[p] <= RST_CFG;
      end else begin
        cfgPort[p] <= next_cfg;
      end
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic access;
  logic writeHit;
  logic next_pready;
  logic next_pslverr;
  logic [31:0] next_prdata;

  // one wait state: pready rises in the second access cycle
  assign access = psel && penable;
  // writes to read-only registers are dropped without an error
  assign writeHit = access && pready && pwrite && !pslverr;
  assign reloadReq = writeHit && (paddr == ecp_pkg::REG_CTRL) &&
                     pwdata[ecp_pkg::CTRL_RELOAD];

  always_comb begin
    next_pready = access && !pready;
    next_pslverr = 1'b0;
    next_prdata = 32'h00000000;
    if (access && !pready) begin
      next_pslverr = !isMapped(paddr);
      if (!pwrite) begin
        unique case (paddr)
          ecp_pkg::REG_CTRL: begin
            // reload is a strobe and always reads back as zero
            next_prdata = 32'h00000000;
          end
          ecp_pkg::REG_STATUS: begin
            next_prdata[ecp_pkg::STAT_BUSY] = loadBusy;
            next_prdata[ecp_pkg::STAT_DONE] = loadDone;
            next_prdata[ecp_pkg::STAT_MATCH] = loadDone && !sigMismatch;
            next_prdata[ecp_pkg::STAT_BAD] = sigMismatch;
          end
          ecp_pkg::REG_IDS: begin
            next_prdata = {ids.deviceId, ids.vendorId};
          end
          ecp_pkg::REG_SUBIDS: begin
            next_prdata = {ids.subsystemId, ids.subVendorId};
          end
          ecp_pkg::REG_W06: begin
            next_prdata = {16'h0000, w06Live};
          end
          ecp_pkg::REG_W0C: begin
            next_prdata = {16'h0000, w0cLive};
          end
          default: begin
            next_prdata = 32'h00000000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

endmodule

// File: ecp_preload_sva.sv
// port checker of the configuration preloader
`timescale 1ns/1ps
module ecp_preload_sva #(
  parameter logic [15:0] SIGNATURE = 16'ha55a
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic wordReq,
  input wire logic [ecp_pkg::ROM_AW-1:0] wordAddr,
  input wire logic [ecp_pkg::WORD_W-1:0] wordData,
  input wire logic wordAck,
  input wire ecp_pkg::ecpIds_type ids,
  input wire ecp_pkg::ecpCfgPort_type [ecp_pkg::NUM_PORTS-1:0] cfgPort,
  input wire logic loadBusy,
  input wire logic loadDone,
  input wire logic sigMismatch
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  ecp_pkg::ecpCfgPort_type p0m;
  ecp_pkg::ecpCfgPort_type p3m;
  logic badSig;
  // downstream-only bits masked so the shared fields can be compared
  always_comb begin
    p0m = cfgPort[0];
    p0m.intaPin = 1'b0;
    p0m.linkBwNotif = 1'b0;
    p3m = cfgPort[3];
    p3m.intaPin = 1'b0;
    p3m.linkBwNotif = 1'b0;
  end
  assign badSig = wordReq && wordAck && wordAddr == 8'h00 && wordData != SIGNATURE;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_apb_answer: assert property (psel && penable && !pready |=> pready)
    else $error("apb access not answered");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_req_hold: assert property (wordReq && !wordAck |=> wordReq && $stable(wordAddr))
    else $error("word request dropped early");
  a_req_drop: assert property (wordReq && wordAck |=> !wordReq) else $error("request kept");
  a_ports_alike: assert property (p0m == p3m && cfgPort[1] == cfgPort[3]
    && cfgPort[2] == cfgPort[3]) else $error("ports differ");
  a_port0_bits: assert property (!cfgPort[0].intaPin && !cfgPort[0].linkBwNotif)
    else $error("port 0 downstream bit set");
  a_mismatch_seen: assert property (badSig |-> ##2 (sigMismatch && loadDone && !loadBusy))
    else $error("bad signature not reported");
  a_mismatch_dflt: assert property ($rose(sigMismatch) |-> cfgPort[1].maxPayload == 2'b01
    && cfgPort[1].roleErrReport && ids.subsystemId == 16'h0000
    && ids.subVendorId == 16'h0000) else $error("defaults not restored");
  a_addr_next: assert property (wordReq && wordAck && wordAddr != 8'h0c && !badSig
    |-> ##3 (wordReq && wordAddr == $past(wordAddr, 3) + 8'h02)) else $error("word order");
  a_load_end: assert property (wordReq && wordAck && wordAddr == 8'h0c
    |-> ##2 (loadDone && !loadBusy && !sigMismatch)) else $error("load did not end");
  c_bad_sig: cover property (badSig);
  c_last_word: cover property (wordAck && wordAddr == 8'h0c);
  c_apb_err: cover property (pslverr);
endmodule

bind ecp_preload ecp_preload_sva #(.SIGNATURE(SIGNATURE)) chk (.clk(clk), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .wordReq(wordReq),
  .wordAddr(wordAddr), .wordData(wordData), .wordAck(wordAck), .ids(ids), .cfgPort(cfgPort),
  .loadBusy(loadBusy), .loadDone(loadDone), .sigMismatch(sigMismatch));

// File: ecp_preload_tb_top.sv
// self-checking bench of the configuration preloader
`timescale 1ns/1ps
module ecp_preload_tb_top;
  localparam logic [15:0] SIG = 16'ha55a;
  typedef struct packed {
    logic isRd;
    logic err;
    logic [31:0] data;
  } ecpExp_type;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, wordReq, wordAck;
  logic loadBusy, loadDone, sigMismatch;
  logic [7:0] paddr, wordAddr;
  logic [31:0] pwdata, prdata, seed;
  logic [15:0] wordData;
  logic [6:0][15:0] image;
  logic [3:0] ackDelay;
  ecp_pkg::ecpIds_type ids;
  ecp_pkg::ecpCfgPort_type [3:0] cfgPort;
  ecpExp_type expQ[$];
  ecpExp_type e;
  int errors, n_compared;

  ecp_preload #(.SIGNATURE(SIG)) uut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wordReq(wordReq), .wordAddr(wordAddr),
    .wordData(wordData), .wordAck(wordAck), .ids(ids), .cfgPort(cfgPort),
    .loadBusy(loadBusy), .loadDone(loadDone), .sigMismatch(sigMismatch));
  ecp_rom_model rom (.clk(clk), .sys_rst(sys_rst), .wordReq(wordReq), .wordAddr(wordAddr),
    .image(image), .ackDelay(ackDelay), .wordData(wordData), .wordAck(wordAck));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic ecp_pkg::ecpCfgPort_type expCfg(input logic [15:0] a, input logic [15:0] c,
      input int p);
    return {a[0], a[3:1], a[6:4], c[3:2], (p != 0) & c[9],
      a[8], a[9], a[10], a[12:11], a[13], a[14],
      c[6], c[5], c[7], (p != 0) & a[15], c[1:0], c[4], c[8]};
  endfunction
  task automatic chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
    n_compared++;
    if (ex !== got) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] ex, input logic er);
    expQ.push_back({~wr, er, ex});
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no limit of its own: only the watchdog ends a lost answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic waitLoad();
    repeat (3) @(posedge clk);
    while (loadDone !== 1'b1) begin
      @(posedge clk);
    end
  endtask
  task automatic checkAll(input logic [15:0] w6, w0c, vid, did, svid, sid, input logic [31:0] st);
    for (int p = 0; p < 4; p++) chk("cfgPort", 64'(expCfg(w6, w0c, p)), 64'(cfgPort[p]));
    chk("ids", {vid, did, svid, sid}, ids);
    apb(1'b0, ecp_pkg::REG_STATUS, 32'h0, st, 1'b0);
    apb(1'b0, ecp_pkg::REG_IDS, 32'h0, {did, vid}, 1'b0);
    apb(1'b0, ecp_pkg::REG_SUBIDS, 32'h0, {sid, svid}, 1'b0);
    apb(1'b0, ecp_pkg::REG_W06, 32'h0, {16'h0000, w6}, 1'b0);
    apb(1'b0, ecp_pkg::REG_W0C, 32'h0, {16'h0000, w0c}, 1'b0);
  endtask
  task automatic newImage();
    image[0] = SIG;
    for (int k = 1; k < 7; k++) begin
      repeat (16) seed = nxt(seed);
      image[k] = seed[15:0];
    end
    ackDelay = seed[19:16];
  endtask
  task end_sim();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // answer monitor and watchdog
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (pready === 1'b1) begin
      if (expQ.size() == 0) begin
        chk("unexpected pready", 64'h1, 64'h0);
      end else begin
        e = expQ.pop_front();
        chk("pslverr", 64'(e.err), 64'(pslverr));
        if (e.isRd) chk("prdata", 64'(e.data), 64'(prdata));
      end
    end
  end
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    $display("watchdog expired");
    end_sim();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    errors = 0;
    n_compared = 0;
    seed = 32'h4748d6c7;
    newImage();
    ackDelay = 4'h0;
    repeat (10) @(posedge clk);
    for (int p = 0; p < 4; p++)
      chk("cfgPort reset", 64'(expCfg(16'h0806, 16'h001d, p)), 64'(cfgPort[p]));
    chk("ids reset", {16'h1234, 16'h5678, 32'h0}, ids);
    sys_rst <= 1'b0;
    waitLoad();
    apb(1'b1, ecp_pkg::REG_IDS, 32'hffffffff, 32'h0, 1'b0);
    apb(1'b0, 8'h18, 32'h0, 32'h0, 1'b1);
    checkAll(image[3], image[6], image[1], image[2], image[4], image[5], 32'h6);
    $display("test 1 done: prompt load");
    image[0] = SIG ^ 16'h0100;
    ackDelay = 4'hf;
    apb(1'b1, ecp_pkg::REG_CTRL, 32'h1, 32'h0, 1'b0);
    apb(1'b1, ecp_pkg::REG_CTRL, 32'h1, 32'h0, 1'b0);
    apb(1'b0, ecp_pkg::REG_STATUS, 32'h0, 32'h1, 1'b0);
    apb(1'b0, ecp_pkg::REG_CTRL, 32'h0, 32'h0, 1'b0);
    waitLoad();
    checkAll(16'h0806, 16'h001d, 16'h1234, 16'h5678, 16'h0, 16'h0, 32'ha);
    $display("test 2 done: bad signature");
    for (int i = 0; i < 4; i++) begin
      newImage();
      apb(1'b1, ecp_pkg::REG_CTRL, 32'h1, 32'h0, 1'b0);
      waitLoad();
      checkAll(image[3], image[6], image[1], image[2], image[4], image[5], 32'h6);
      $display("test %0d done: random reload", i + 3);
    end
    @(posedge clk);
    chk("pending answers", 64'h0, 64'(expQ.size()));
    end_sim();
  end
endmodule

// File: ecp_rom_model.sv
// serial eeprom word store answering the preloader's word requests
`timescale 1ns/1ps
module ecp_rom_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wordReq,
  input wire logic [7:0] wordAddr,
  input wire logic [6:0][15:0] image,
  input wire logic [3:0] ackDelay,
  output logic [15:0] wordData,
  output logic wordAck
);
  logic [3:0] cnt;
  // data toggles outside the ack cycle so a sample one cycle late never matches
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wordAck <= 1'b0;
      wordData <= 16'h0000;
      cnt <= 4'h0;
    end else if (wordReq && !wordAck && cnt >= ackDelay) begin
      wordAck <= 1'b1;
      wordData <= image[wordAddr[3:1]];
      cnt <= 4'h0;
    end else begin
      wordAck <= 1'b0;
      wordData <= ~wordData;
      cnt <= (wordReq && !wordAck) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule

// File: ecp_word_fetch.sv
// one-word request/answer handshake towards the eeprom word reader
`timescale 1ns/1ps
module ecp_word_fetch (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [ecp_pkg::ROM_AW-1:0] addr,
  output logic done,
  output logic [ecp_pkg::WORD_W-1:0] data,
  output logic wordReq,
  output logic [ecp_pkg::ROM_AW-1:0] wordAddr,
  input wire logic [ecp_pkg::WORD_W-1:0] wordData,
  input wire logic wordAck
);

  logic next_done;
  logic [ecp_pkg::WORD_W-1:0] next_data;
  logic next_wordReq;
  logic [ecp_pkg::ROM_AW-1:0] next_wordAddr;

  // ----------------------------------------------------------------
  // request held until acknowledged
  // ----------------------------------------------------------------
  always_comb begin
    next_done = 1'b0;
    next_data = data;
    next_wordReq = wordReq;
    next_wordAddr = wordAddr;
    if (wordReq && wordAck) begin
      next_wordReq = 1'b0;
      next_data = wordData;
      next_done = 1'b1;
    end else if (!wordReq && start) begin
      next_wordReq = 1'b1;
      next_wordAddr = addr;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      done <= 1'b0;
      data <= 16'h0000;
      wordReq <= 1'b0;
      wordAddr <= 8'h00;
    end else begin
      done <= next_done;
      data <= next_data;
      wordReq <= next_wordReq;
      wordAddr <= next_wordAddr;
    end
  end

endmodule
